// [flash_self_program_sequencer_tb.sv]
// Self-checking bench joining the processor end and the sequencer end.
`timescale 1ns/1ns
`default_nettype none
module flash_self_program_sequencer_tb;
  import fsps_pkg::*;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [1:0]  br;
    logic [7:0]  ra;
    logic [31:0] rd;
    logic [1:0]  rr;
  } fsps_row_type;
  localparam logic [1:0] OK = FSPS_RESP_OKAY;
  localparam logic [1:0] SE = FSPS_RESP_SLV;
  localparam fsps_row_type ROWS [7] = '{
    '{FSPS_OFS_ADDR, 32'h0000_0040, OK, FSPS_OFS_ADDR, 32'h0000_0040, OK},
    '{FSPS_OFS_CTRL, 32'h0000_FFFF, OK, FSPS_OFS_STATUS, 32'h0000_4043, OK},
    '{FSPS_OFS_CTRL, 32'h0000_0041, OK, FSPS_OFS_CTRL, 32'h0000_0041, OK},
    '{FSPS_OFS_KEY, 32'h0000_0055, OK, FSPS_OFS_KEY, 32'h0000_0000, OK},
    '{FSPS_OFS_DATA, 32'h0012_3456, OK, FSPS_OFS_DATA, 32'h0000_0000, OK},
    '{8'h20, 32'h0000_0001, SE, 8'h20, 32'h0000_0000, SE},
    '{FSPS_OFS_STATUS, 32'hFFFF_FFFF, OK, FSPS_OFS_STATUS, 32'h0000_0041, OK}};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, fl_prog, fl_erase;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdat;
  logic [1:0]  bresp, rresp, last_b, rres;
  logic [15:0] fl_addr;
  logic [23:0] fl_wdata;
  logic [39:0] pr_q [$];
  logic [15:0] er_q [$];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  fsps_link_if link();
  fsps_dev #(.AW(16), .PROG_CYCLES(4), .ERASE_CYCLES(16)) u_fsps_dev (.aclk(aclk),
    .aresetn(aresetn), .link(link), .fl_prog(fl_prog), .fl_erase(fl_erase),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata));
  fsps_host u_fsps_host (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  fsps_asserts u_fsps_asserts (.aclk(aclk), .aresetn(aresetn), .req_valid(link.req_valid),
    .req_ready(link.req_ready), .req_kind(link.req_kind), .req_data(link.req_data),
    .stall(link.stall), .ctrl_rd(link.ctrl_rd));
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (fl_prog)
      pr_q.push_back({fl_addr, fl_wdata});
    if (fl_erase)
      er_q.push_back(fl_addr);
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // --------------------------------------------------------------------
  // Bus tasks and comparisons
  // --------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        last_b = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rdat = rdata;
        rres = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk2(input logic [1:0] got, input logic [1:0] exp);
    chk32({30'h0, got}, {30'h0, exp});
  endtask
  task automatic keys();
    wr(FSPS_OFS_KEY, 32'h0000_0055);
    wr(FSPS_OFS_KEY, 32'h0000_00AA);
  endtask
  task automatic go(input logic [31:0] c);
    pr_q.delete();
    er_q.delete();
    keys();
    wr(FSPS_OFS_CTRL, c);
    while (link.stall)
      @(posedge aclk);
  endtask
  function automatic logic [23:0] pat(input logic [4:0] i);
    return {i, 8'h3C, ~i, 6'h15};
  endfunction
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FSPS_OFS_STATUS);
    chk32(rdat, 32'h0000_0000);
    $display("reset values done");
    foreach (ROWS[k])
    begin
      wr(ROWS[k].wa, ROWS[k].wd);
      chk2(last_b, ROWS[k].br);
      rd(ROWS[k].ra);
      chk32(rdat, ROWS[k].rd);
      chk2(rres, ROWS[k].rr);
    end
    $display("register table done");
    pr_q.delete();
    wr(FSPS_OFS_ADDR, 32'h0000_0045);
    wr(FSPS_OFS_DATA, 32'h0000_0000);
    for (int i = 31; i >= 0; i--)
    begin
      wr(FSPS_OFS_ADDR, 32'h0000_0040 + i);
      wr(FSPS_OFS_DATA, {8'h00, pat(i[4:0])});
    end
    chk32(pr_q.size(), 32'h0000_0000);
    wr(FSPS_OFS_ADDR, 32'h0000_0045);
    keys();
    fork
      wr(FSPS_OFS_CTRL, 32'h0000_C001);
      begin
        repeat (12) @(posedge aclk);
        rd(FSPS_OFS_STATUS);
        chk32(rdat, 32'h0001_C001);
      end
    join
    wr(FSPS_OFS_ADDR, 32'h0000_0067);
    chk32({31'h0, link.stall}, 32'h0000_0000);
    chk32(pr_q.size(), 32'h0000_0020);
    foreach (pr_q[i])
    begin
      chk32({16'h0, pr_q[i][39:24]}, 32'h0000_0040 + i);
      chk32({8'h0, pr_q[i][23:0]}, {8'h0, pat(i[4:0])});
    end
    rd(FSPS_OFS_CTRL);
    chk32(rdat, 32'h0000_4001);
    $display("row program done");
    go(32'h0000_C000);
    chk32(pr_q.size(), 32'h0000_0001);
    chk32(pr_q[0][31:0], {8'h67, pat(5'h07)});
    $display("word program done");
    for (int s = 0; s < 3; s++)
    begin
      wr(FSPS_OFS_ADDR, 32'h0000_00A5);
      go(32'h0000_C040 | s);
      chk32(er_q.size(), 32'h0000_0001 << s);
      foreach (er_q[k])
        chk32({16'h0, er_q[k]}, (32'h0000_00A5 & ~((32'h0000_0020 << s) - 1)) + 32 * k);
    end
    $display("erase done");
    pr_q.delete();
    wr(FSPS_OFS_KEY, 32'h0000_0055);
    wr(FSPS_OFS_ADDR, 32'h0000_0047);
    wr(FSPS_OFS_KEY, 32'h0000_00AA);
    wr(FSPS_OFS_CTRL, 32'h0000_C001);
    rd(FSPS_OFS_CTRL);
    chk32(rdat, 32'h0000_4001);
    foreach (ROWS[k])
    begin
      if (k < 2)
      begin
        go(k == 0 ? 32'h0000_C003 : 32'h0000_8001);
        rd(FSPS_OFS_CTRL);
        chk32(rdat, k == 0 ? 32'h0000_4003 : 32'h0000_0001);
      end
    end
    chk32(pr_q.size() + er_q.size(), 32'h0000_0000);
    $display("refusals done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(FSPS_OFS_CTRL);
    chk32(rdat, 32'h0000_0000);
    $display("second reset done");
    summarize();
  end
endmodule
`default_nettype wire

// [fsps_asserts.sv]
// Concurrent checks on the link between the processor end and the sequencer end.
`timescale 1ns/1ns
`default_nettype none
module fsps_asserts
  import fsps_pkg::*;
(
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire fsps_req_type           req_kind,
  input wire logic [FSPS_WORD_W-1:0] req_data,
  input wire logic                   stall,
  input wire logic [FSPS_CTRL_W-1:0] ctrl_rd
);
  localparam int MAX_RUN = 300;
  logic take;
  logic ctrl_take;
  logic start_ok;
  logic key_first_reg;
  logic unlocked_reg;
  assign take      = req_valid && req_ready;
  assign ctrl_take = take && req_kind == FSPS_REQ_CTRL;
  assign start_ok  = unlocked_reg && req_data[FSPS_START_BIT] && req_data[FSPS_WREN_BIT]
                     && req_data[1:0] != FSPS_SEL_BAD
                     && (req_data[FSPS_ERASE_BIT] || !req_data[1]);
  // Tracks whether the last two taken requests were the two key values in order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      key_first_reg <= 1'b0;
      unlocked_reg  <= 1'b0;
    end
    else if (take)
    begin
      key_first_reg <= req_kind == FSPS_REQ_KEY && req_data[7:0] == FSPS_KEY_FIRST;
      unlocked_reg  <= req_kind == FSPS_REQ_KEY && req_data[7:0] == FSPS_KEY_SECOND
                       && key_first_reg;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_launch;
    ctrl_take && start_ok;
  endsequence
  sequence s_started;
    stall && ctrl_rd == (16'h8000 | ($past(req_data[15:0]) & FSPS_CTRL_MASK));
  endsequence
  AST_LAUNCH: assert property (s_launch |=> s_started)
    else $error("start not launched after unlock");
  AST_REFUSE: assert property (ctrl_take && !start_ok |=> !stall
    && ctrl_rd == ($past(req_data[15:0]) & FSPS_CTRL_MASK)) else $error("start not refused");
  AST_NO_SELF_START: assert property (!ctrl_take && !stall |=> !stall)
    else $error("operation began without a control write");
  AST_TABLE_BUSY: assert property (take && req_kind == FSPS_REQ_TABLE |=> !req_ready)
    else $error("table write took one cycle");
  AST_ONE_TAKE: assert property (take |=> !req_valid)
    else $error("request repeated after being taken");
  AST_STALL_BLOCK: assert property (stall |-> !req_ready)
    else $error("request accepted while stalled");
  AST_STALL_END: assert property ($rose(stall) |-> ##[1:MAX_RUN] !stall)
    else $error("operation never finished");
  AST_RUN_START: assert property (stall |-> ctrl_rd[FSPS_START_BIT])
    else $error("start bit low while running");
  AST_CLEAR: assert property ($fell(stall) |-> !ctrl_rd[FSPS_START_BIT])
    else $error("start bit not cleared at finish");
  AST_CTRL_HOLD: assert property (!stall && !ctrl_take |=> $stable(ctrl_rd))
    else $error("control value changed on its own");
endmodule
`default_nettype wire

// [fsps_dev.sv]
// Flash self-programming sequencer: latches, unlock, erase and program.
`timescale 1ns/1ns
`default_nettype none
module fsps_dev
  import fsps_pkg::*;
#(
  parameter int AW           = FSPS_ADDR_W,
  parameter int PROG_CYCLES  = 4,
  parameter int ERASE_CYCLES = 16
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  fsps_link_if.dev              link,
  output logic                  fl_prog,
  output logic                  fl_erase,
  output logic [AW-1:0]         fl_addr,
  output logic [FSPS_WORD_W-1:0] fl_wdata
);

  if (AW < FSPS_IDX_W + 2 || AW > FSPS_WORD_W || PROG_CYCLES < 1 || ERASE_CYCLES < 1 ||
      PROG_CYCLES > 65535 || ERASE_CYCLES > 65535)
  begin : g_check
    $error("fsps_dev: unsupported parameters");
  end

  localparam logic [15:0] PROG_WAIT  = 16'(PROG_CYCLES - 1);
  localparam logic [15:0] ERASE_WAIT = 16'(ERASE_CYCLES - 1);
  localparam logic [7:0]  ROW_CNT    = 8'(FSPS_ROW_WORDS);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ERASE,
    ST_PROG
  } fsps_state_type;

  typedef struct packed {
    fsps_state_type         st;
    logic [FSPS_CTRL_W-1:0] ctrl;
    logic [AW-1:0]          nv_addr;
    logic                   key_half;
    logic                   unlocked;
    logic                   tw_hold;
    logic [AW-1:0]          cur;
    logic [7:0]             left;
    logic [15:0]            wait_cnt;
    logic                   fl_prog;
    logic                   fl_erase;
    logic [AW-1:0]          fl_addr;
    logic [FSPS_WORD_W-1:0] fl_wdata;
  } fsps_dev_type;

  fsps_dev_type           q_reg;
  fsps_dev_type           q_next;
  logic                   take;
  logic                   table_wr;
  logic [1:0]             sel;
  logic [AW-1:0]          emask;
  logic [AW-1:0]          rmask;
  logic [FSPS_WORD_W-1:0] latch_rd;

  // --------------------------------------------------------------------
  // Request acceptance
  // --------------------------------------------------------------------
  // A table write blocks the next request for one cycle, so it takes two.
  assign link.req_ready = (q_reg.st == ST_IDLE) && !q_reg.tw_hold;
  assign link.stall     = (q_reg.st != ST_IDLE);
  assign link.ctrl_rd   = q_reg.ctrl;
  assign take           = link.req_valid && link.req_ready;
  assign table_wr       = take && (link.req_kind == FSPS_REQ_TABLE);
  assign sel            = link.req_data[1:0];
  // Erase block of 1, 2 or 4 rows, aligned from word zero.
  assign emask = (AW'(FSPS_ROW_WORDS) << sel) - AW'(1);
  assign rmask = AW'(FSPS_ROW_WORDS) - AW'(1);

  // --------------------------------------------------------------------
  // Holding latches
  // --------------------------------------------------------------------
  fsps_latch_buf #(
    .W (FSPS_WORD_W),
    .N (FSPS_ROW_WORDS)
  ) u_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (table_wr),
    .wr_idx  (q_reg.nv_addr[FSPS_IDX_W-1:0]),
    .wr_data (link.req_data),
    .rd_idx  (q_reg.cur[FSPS_IDX_W-1:0]),
    .rd_data (latch_rd)
  );

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb
  begin
    q_next          = q_reg;
    q_next.fl_prog  = 1'b0;
    q_next.fl_erase = 1'b0;
    q_next.tw_hold  = table_wr;
    if (take)
    begin
      // Any write other than the key sequence breaks the unlock.
      q_next.key_half = 1'b0;
      q_next.unlocked = 1'b0;
      case (link.req_kind)
        FSPS_REQ_KEY:
        begin
          if (link.req_data[7:0] == FSPS_KEY_FIRST)
          begin
            q_next.key_half = 1'b1;
          end
          else if (link.req_data[7:0] == FSPS_KEY_SECOND && q_reg.key_half)
          begin
            q_next.unlocked = 1'b1;
          end
        end
        FSPS_REQ_ADDR:
        begin
          q_next.nv_addr = link.req_data[AW-1:0];
        end
        FSPS_REQ_CTRL:
        begin
          q_next.ctrl = link.req_data[FSPS_CTRL_W-1:0] & FSPS_CTRL_MASK;
          if (link.req_data[FSPS_START_BIT] && link.req_data[FSPS_WREN_BIT] &&
              q_reg.unlocked && sel != FSPS_SEL_BAD)
          begin
            q_next.ctrl[FSPS_START_BIT] = 1'b1;
            q_next.wait_cnt             = 16'h0000;
            if (link.req_data[FSPS_ERASE_BIT])
            begin
              q_next.st   = ST_ERASE;
              q_next.cur  = q_reg.nv_addr & ~emask;
              q_next.left = 8'h01 << sel;
            end
            else if (sel == FSPS_SEL_ROW)
            begin
              q_next.st   = ST_PROG;
              q_next.cur  = q_reg.nv_addr & ~rmask;
              q_next.left = ROW_CNT;
            end
            else if (sel == FSPS_SEL_WORD)
            begin
              q_next.st   = ST_PROG;
              q_next.cur  = q_reg.nv_addr;
              q_next.left = 8'h01;
            end
            else
            begin
              q_next.ctrl[FSPS_START_BIT] = 1'b0;
            end
          end
        end
        default:
        begin
          q_next.tw_hold = table_wr;
        end
      endcase
    end
    case (q_reg.st)
      ST_ERASE, ST_PROG:
      begin
        if (q_reg.wait_cnt != 16'h0000)
        begin
          q_next.wait_cnt = q_reg.wait_cnt - 16'h0001;
        end
        else if (q_reg.left == 8'h00)
        begin
          q_next.st                   = ST_IDLE;
          q_next.ctrl[FSPS_START_BIT] = 1'b0;
        end
        else
        begin
          q_next.left    = q_reg.left - 8'h01;
          q_next.fl_addr = q_reg.cur;
          if (q_reg.st == ST_ERASE)
          begin
            q_next.fl_erase = 1'b1;
            q_next.cur      = q_reg.cur + AW'(FSPS_ROW_WORDS);
            q_next.wait_cnt = ERASE_WAIT;
          end
          else
          begin
            q_next.fl_prog  = 1'b1;
            q_next.fl_wdata = latch_rd;
            q_next.cur      = q_reg.cur + AW'(1);
            q_next.wait_cnt = PROG_WAIT;
          end
        end
      end
      default:
      begin
        q_next.wait_cnt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg          <= '0;
      q_reg.st       <= ST_IDLE;
      q_reg.ctrl     <= FSPS_CTRL_RESET;
      q_reg.fl_wdata <= '1;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign fl_prog  = q_reg.fl_prog;
  assign fl_erase = q_reg.fl_erase;
  assign fl_addr  = q_reg.fl_addr;
  assign fl_wdata = q_reg.fl_wdata;

endmodule
`default_nettype wire

// [fsps_host.sv]
// Processor end: AXI4-Lite registers turned into link requests.
`timescale 1ns/1ns
`default_nettype none
module fsps_host
  import fsps_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  fsps_link_if.host                   link,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [FSPS_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic      [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [FSPS_AXI_AW-1:0] s_axi_araddr,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic      [31:0]            s_axi_rdata,
  output logic      [1:0]             s_axi_rresp
);

  typedef struct packed {
    logic                   aw_got;
    logic                   w_got;
    logic [FSPS_AXI_AW-1:0] wa;
    logic [31:0]            wd;
    logic                   pend;
    fsps_req_type           kind;
    logic [FSPS_WORD_W-1:0] data;
    logic [FSPS_WORD_W-1:0] addr_sh;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } fsps_host_type;

  fsps_host_type q_reg;
  fsps_host_type q_next;
  logic          unused_strb;

  assign unused_strb   = ^s_axi_wstrb;
  assign s_axi_awready = !q_reg.aw_got && !q_reg.bvalid;
  assign s_axi_wready  = !q_reg.w_got && !q_reg.bvalid;
  assign s_axi_arready = !q_reg.rvalid;

  // --------------------------------------------------------------------
  // Write and read paths
  // --------------------------------------------------------------------
  always_comb
  begin
    q_next = q_reg;
    if (s_axi_awvalid && s_axi_awready)
    begin
      q_next.aw_got = 1'b1;
      q_next.wa     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      q_next.w_got = 1'b1;
      q_next.wd    = s_axi_wdata;
    end
    if (q_reg.aw_got && q_reg.w_got && !q_reg.pend && !q_reg.bvalid)
    begin
      q_next.aw_got = 1'b0;
      q_next.w_got  = 1'b0;
      q_next.pend   = 1'b1;
      q_next.data   = q_reg.wd[FSPS_WORD_W-1:0];
      case (q_reg.wa)
        FSPS_OFS_ADDR:
        begin
          q_next.kind    = FSPS_REQ_ADDR;
          q_next.addr_sh = q_reg.wd[FSPS_WORD_W-1:0];
        end
        FSPS_OFS_DATA:
        begin
          q_next.kind = FSPS_REQ_TABLE;
        end
        FSPS_OFS_CTRL:
        begin
          q_next.kind = FSPS_REQ_CTRL;
        end
        FSPS_OFS_KEY:
        begin
          q_next.kind = FSPS_REQ_KEY;
        end
        default:
        begin
          q_next.pend   = 1'b0;
          q_next.bvalid = 1'b1;
          q_next.bresp  = (q_reg.wa == FSPS_OFS_STATUS) ? FSPS_RESP_OKAY : FSPS_RESP_SLV;
        end
      endcase
    end
    // The write answer waits for the sequencer, so a stall holds later writes; reads still answer.
    if (q_reg.pend && link.req_ready)
    begin
      q_next.pend   = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp  = FSPS_RESP_OKAY;
    end
    if (q_reg.bvalid && s_axi_bready)
    begin
      q_next.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      q_next.rvalid = 1'b1;
      q_next.rresp  = FSPS_RESP_OKAY;
      q_next.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        FSPS_OFS_ADDR:   q_next.rdata = 32'(q_reg.addr_sh);
        FSPS_OFS_CTRL:   q_next.rdata = 32'(link.ctrl_rd);
        FSPS_OFS_STATUS: q_next.rdata = 32'({link.stall, link.ctrl_rd});
        FSPS_OFS_DATA, FSPS_OFS_KEY: q_next.rdata = 32'h0000_0000;
        default:         q_next.rresp = FSPS_RESP_SLV;
      endcase
    end
    else if (q_reg.rvalid && s_axi_rready)
    begin
      q_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg      <= '0;
      q_reg.kind <= FSPS_REQ_TABLE;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign link.req_valid = q_reg.pend;
  assign link.req_kind  = q_reg.kind;
  assign link.req_data  = q_reg.data;
  assign s_axi_bvalid   = q_reg.bvalid;
  assign s_axi_bresp    = q_reg.bresp;
  assign s_axi_rvalid   = q_reg.rvalid;
  assign s_axi_rdata    = q_reg.rdata;
  assign s_axi_rresp    = q_reg.rresp;

endmodule
`default_nettype wire

// [fsps_latch_buf.sv]
// Row holding latches written by table writes and read by the sequencer.
`timescale 1ns/1ns
`default_nettype none
module fsps_latch_buf
  import fsps_pkg::*;
#(
  parameter int W = FSPS_WORD_W,
  parameter int N = FSPS_ROW_WORDS
)(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 wr_en,
  input  wire logic [$clog2(N)-1:0] wr_idx,
  input  wire logic [W-1:0]         wr_data,
  input  wire logic [$clog2(N)-1:0] rd_idx,
  output logic      [W-1:0]         rd_data
);

  if (N < 2 || W < 1)
  begin : g_check
    $error("fsps_latch_buf: unsupported size");
  end

  typedef struct packed {
    logic [N-1:0][W-1:0] mem;
  } fsps_latch_type;

  fsps_latch_type q_reg;
  fsps_latch_type q_next;

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  always_comb
  begin
    q_next = q_reg;
    if (wr_en)
    begin
      q_next.mem[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q_reg <= '1;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign rd_data = q_reg.mem[rd_idx];

endmodule
`default_nettype wire

// [fsps_link_if.sv]
// Link between the processor end and the flash sequencer end.
`timescale 1ns/1ns
`default_nettype none
interface fsps_link_if;
  import fsps_pkg::*;
  logic                   req_valid;
  logic                   req_ready;
  fsps_req_type           req_kind;
  logic [FSPS_WORD_W-1:0] req_data;
  logic                   stall;
  logic [FSPS_CTRL_W-1:0] ctrl_rd;

  modport dev (
    input  req_valid,
    input  req_kind,
    input  req_data,
    output req_ready,
    output stall,
    output ctrl_rd
  );

  modport host (
    output req_valid,
    output req_kind,
    output req_data,
    input  req_ready,
    input  stall,
    input  ctrl_rd
  );
endinterface
`default_nettype wire

// [fsps_pkg.sv]
// Shared constants and types for the flash self-programming sequencer.
package fsps_pkg;

  // ----------------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------------
  localparam int FSPS_ADDR_W    = 16;
  localparam int FSPS_WORD_W    = 24;
  localparam int FSPS_ROW_WORDS = 32;
  localparam int FSPS_ROW_BYTES = 96;
  localparam int FSPS_IDX_W     = 5;

  // ----------------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------------
  localparam int               FSPS_CTRL_W     = 16;
  localparam int               FSPS_START_BIT  = 15;
  localparam int               FSPS_WREN_BIT   = 14;
  localparam int               FSPS_ERASE_BIT  = 6;
  localparam logic [15:0]      FSPS_CTRL_RESET = 16'h0000;
  localparam logic [15:0]      FSPS_CTRL_MASK  = 16'h4043;
  localparam logic [1:0]       FSPS_SEL_WORD   = 2'h0;
  localparam logic [1:0]       FSPS_SEL_ROW    = 2'h1;
  localparam logic [1:0]       FSPS_SEL_BAD    = 2'h3;
  localparam logic [7:0]       FSPS_KEY_FIRST  = 8'h55;
  localparam logic [7:0]       FSPS_KEY_SECOND = 8'hAA;

  // ----------------------------------------------------------------------
  // Processor-side register offsets
  // ----------------------------------------------------------------------
  localparam int          FSPS_AXI_AW     = 8;
  localparam logic [7:0]  FSPS_OFS_ADDR   = 8'h00;
  localparam logic [7:0]  FSPS_OFS_DATA   = 8'h04;
  localparam logic [7:0]  FSPS_OFS_CTRL   = 8'h08;
  localparam logic [7:0]  FSPS_OFS_KEY    = 8'h0C;
  localparam logic [7:0]  FSPS_OFS_STATUS = 8'h10;
  localparam logic [1:0]  FSPS_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  FSPS_RESP_SLV   = 2'h2;

  typedef enum logic [1:0] {
    FSPS_REQ_TABLE,
    FSPS_REQ_CTRL,
    FSPS_REQ_KEY,
    FSPS_REQ_ADDR
  } fsps_req_type;

endpackage
